//--- hdl/aocs_aux_channel.v
// one auxiliary output scheduled against a trigger position
`timescale 1ns/1ps
`include "aocs_map.vh"

module aocs_aux_channel (
    input  wire       clk,
    input  wire       nrst,
    input  wire       minute_tick,
    input  wire       in_trigger,
    input  wire [1:0] mode,
    input  wire [7:0] delay_min,
    input  wire [7:0] on_min,
    input  wire [7:0] off_min,
    output reg        out
);

    reg  [1:0] phase;
    reg  [7:0] cnt;
    reg        was_in;
    wire       dflt  = (mode == `AOCS_MODE_ENERGIZED);
    wire       tog   = (mode == `AOCS_MODE_TOGGLE);
    wire       entry = in_trigger & ~was_in;
    wire       last  = minute_tick & (cnt <= 8'h01);

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase  <= `AOCS_PH_IDLE;
            cnt    <= 8'h00;
            // no false entry right after reset
            was_in <= 1'b1;
        end else begin
            was_in <= in_trigger;
            // R18 restart on entry
            if (entry) begin
                // R3 zero delay acts at once
                if (delay_min != 8'h00) begin
                    phase <= `AOCS_PH_DELAY;
                    cnt   <= delay_min;
                end else if (on_min != 8'h00) begin
                    phase <= `AOCS_PH_ACTIVE;
                    cnt   <= on_min;
                end else begin
                    phase <= `AOCS_PH_IDLE;
                end
            // R2 change only inside trigger position
            end else if (!in_trigger) begin
                phase <= `AOCS_PH_IDLE;
            end else begin
                case (phase)
                    `AOCS_PH_DELAY: begin
                        // R3 wait delay minutes
                        if (last) begin
                            phase <= (on_min != 8'h00) ? `AOCS_PH_ACTIVE : `AOCS_PH_IDLE;
                            cnt   <= on_min;
                        end else if (minute_tick) begin
                            cnt <= cnt - 8'h01;
                        end
                    end
                    `AOCS_PH_ACTIVE: begin
                        // R4 R17 hold for on time
                        if (last) begin
                            // R5 R6 rest only when toggling
                            if (tog && off_min != 8'h00) begin
                                phase <= `AOCS_PH_REST;
                                cnt   <= off_min;
                            end else if (tog) begin
                                cnt <= on_min;
                            end else begin
                                phase <= `AOCS_PH_IDLE;
                            end
                        end else if (minute_tick) begin
                            cnt <= cnt - 8'h01;
                        end
                    end
                    `AOCS_PH_REST: begin
                        // R5 off time then on again
                        if (last) begin
                            phase <= `AOCS_PH_ACTIVE;
                            cnt   <= on_min;
                        end else if (minute_tick) begin
                            cnt <= cnt - 8'h01;
                        end
                    end
                    default: phase <= `AOCS_PH_IDLE;
                endcase
            end
        end
    end

    // R1 default level outside the active phase
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out <= 1'b0;
        end else begin
            out <= (phase == `AOCS_PH_ACTIVE) ? ~dflt : dflt;
        end
    end

endmodule // aocs_aux_channel

//--- hdl/aocs_map.vh
// constants for the auxiliary output cycle sequencer
`ifndef AOCS_MAP_VH
`define AOCS_MAP_VH

// output modes
`define AOCS_MODE_ENERGIZED   2'h0
`define AOCS_MODE_DEENERGIZED 2'h1
`define AOCS_MODE_TOGGLE      2'h2

// valve cycle positions
`define AOCS_POS_SERVICE      2'h0
`define AOCS_POS_BACKWASH     2'h1
`define AOCS_POS_DRAW_RINSE   2'h2
`define AOCS_POS_FAST_RINSE   2'h3

// time base: one minute in seconds, clock rate in hertz
`define AOCS_MINUTE_S         64'h0000_0000_0000_003C
`define AOCS_CLK_HZ           64'h0000_0000_02FA_F080

// time of day in minutes after midnight
`define AOCS_DAY_MINUTES      11'h5A0
`define AOCS_REGEN_TOD_RESET  11'h078

// sequencer states
`define AOCS_ST_IDLE          3'h0
`define AOCS_ST_GRANT         3'h1
`define AOCS_ST_MOVE          3'h2
`define AOCS_ST_DWELL         3'h3
`define AOCS_ST_PARK          3'h4

// channel phases
`define AOCS_PH_IDLE          2'h0
`define AOCS_PH_DELAY         2'h1
`define AOCS_PH_ACTIVE        2'h2
`define AOCS_PH_REST          2'h3

`endif

//--- hdl/aocs_sequencer.v
// regeneration sequencer with four scheduled auxiliary outputs
// How it works
// R1 - three modes: energized, deenergized, periodic toggle
// R2 - output changes only in its trigger position
// R3 - programmable minute delay, zero acts immediately
// R4 - hold non-default for on time, then revert
// R5 - toggle mode cycles on/off through the position
// R6 - off time ignored outside toggle mode
// R7 - four independently scheduled auxiliary outputs
// R8 - motor on output one forces standby output four
// R9 - standby output energized everywhere except service
// R10 - deferred request starts at regen time of day
// R11 - immediate request starts regeneration at once
// R12 - follower asks lead unit, waits for grant
// R13 - manual cycling in service and regeneration, report
// R14 - continuous run or stop after each position
// R15 - motor position reported as four codes
// R16 - next cycle, end now, cancel pending trigger
// R17 - deenergized mode: on time is contact time
// R18 - minute tick counters restart on trigger entry
// R19 - reset gives default outputs, cleared counters; reset loads 0 on every output, also on energized channels
`timescale 1ns/1ps
`include "aocs_map.vh"

module aocs_sequencer #(
    parameter [63:0] MINUTE_CYCLES = `AOCS_MINUTE_S * `AOCS_CLK_HZ
) (
    input  wire        clk,
    input  wire        nrst,
    input  wire [7:0]  aux_mode,
    input  wire [7:0]  aux_trigger_pos,
    input  wire [31:0] activation_delay_minutes,
    input  wire [31:0] active_duration_minutes,
    input  wire [31:0] inactive_duration_minutes,
    input  wire        motor_on_aux1,
    input  wire [23:0] regen_step_minutes,
    input  wire        set_time,
    input  wire [10:0] time_value,
    input  wire        set_regen_time,
    input  wire [10:0] regen_time_value,
    input  wire        deferred_regeneration,
    input  wire        immediate_regeneration,
    input  wire        next_cycle,
    input  wire        end_regen_now,
    input  wire        cancel_pending_trigger,
    input  wire        manual_continuous,
    input  wire        manual_step,
    input  wire        follower_mode,
    input  wire        lead_grant,
    input  wire [3:0]  valve_switch,
    output reg  [3:0]  aux_out,
    output reg         motor_run,
    output reg  [1:0]  cycle_pos,
    output reg  [7:0]  minutes_left,
    output reg         regen_active,
    output reg         regen_pending,
    output reg         lead_request,
    output reg         valve_at_service,
    output reg         valve_at_backwash,
    output reg         valve_at_draw_rinse,
    output reg         valve_at_fast_rinse_refill
);

    function [1:0] next_pos;
        input [1:0] p;
        begin
            next_pos = p + 2'h1;
        end
    endfunction

    function [7:0] step_minutes;
        input [1:0]  p;
        input [23:0] tbl;
        begin
            case (p)
                `AOCS_POS_BACKWASH:   step_minutes = tbl[7:0];
                `AOCS_POS_DRAW_RINSE: step_minutes = tbl[15:8];
                `AOCS_POS_FAST_RINSE: step_minutes = tbl[23:16];
                default:              step_minutes = 8'h00;
            endcase
        end
    endfunction

    reg  [31:0] div_cnt;
    reg         minute_tick;
    reg  [10:0] tod;
    reg  [10:0] regen_tod;
    reg  [3:0]  sw_meta;
    reg  [3:0]  sw_sync;
    reg         grant_meta;
    reg         grant_sync;
    reg  [2:0]  state;
    reg  [1:0]  target;
    reg         cont;
    wire [3:0]  ch_out;
    wire        arrived = sw_sync[target];
    wire        start_req = immediate_regeneration |
                    (regen_pending & minute_tick & (tod == regen_tod));

    // R18 one-minute tick from the clock
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt     <= 32'h0000_0000;
            minute_tick <= 1'b0;
        end else if (div_cnt == MINUTE_CYCLES[31:0] - 32'h0000_0001) begin
            div_cnt     <= 32'h0000_0000;
            minute_tick <= 1'b1;
        end else begin
            div_cnt     <= div_cnt + 32'h0000_0001;
            minute_tick <= 1'b0;
        end
    end

    // time of day and programmed regeneration time
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tod       <= 11'h000;
            regen_tod <= `AOCS_REGEN_TOD_RESET;
        end else begin
            if (set_time) begin
                tod <= time_value;
            end else if (minute_tick) begin
                tod <= (tod == `AOCS_DAY_MINUTES - 11'h001) ? 11'h000 : tod + 11'h001;
            end
            if (set_regen_time) begin
                regen_tod <= regen_time_value;
            end
        end
    end

    // switches and grant come from outside, two flops each
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sw_meta    <= 4'h0;
            sw_sync    <= 4'h0;
            grant_meta <= 1'b0;
            grant_sync <= 1'b0;
        end else begin
            sw_meta    <= valve_switch;
            sw_sync    <= sw_meta;
            grant_meta <= lead_grant;
            grant_sync <= grant_meta;
        end
    end

    // R15 position codes from switches
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            valve_at_service           <= 1'b0;
            valve_at_backwash          <= 1'b0;
            valve_at_draw_rinse        <= 1'b0;
            valve_at_fast_rinse_refill <= 1'b0;
        end else begin
            valve_at_service           <= sw_sync[`AOCS_POS_SERVICE];
            valve_at_backwash          <= sw_sync[`AOCS_POS_BACKWASH];
            valve_at_draw_rinse        <= sw_sync[`AOCS_POS_DRAW_RINSE];
            valve_at_fast_rinse_refill <= sw_sync[`AOCS_POS_FAST_RINSE];
        end
    end

    // regeneration and manual motor sequencer
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state         <= `AOCS_ST_IDLE;
            target        <= `AOCS_POS_SERVICE;
            cycle_pos     <= `AOCS_POS_SERVICE;
            cont          <= 1'b0;
            minutes_left  <= 8'h00;
            regen_active  <= 1'b0;
            regen_pending <= 1'b0;
            lead_request  <= 1'b0;
        end else begin
            // R10 a new deferred request beats a same-cycle cancel
            if (deferred_regeneration) begin
                regen_pending <= 1'b1;
            // R16 cancel a pending trigger
            end else if (cancel_pending_trigger) begin
                regen_pending <= 1'b0;
            end
            case (state)
                `AOCS_ST_IDLE: begin
                    // R10 R11 start now or at the set time
                    if (start_req) begin
                        // a same-cycle deferred request stays pending
                        if (!deferred_regeneration) begin
                            regen_pending <= 1'b0;
                        end
                        // R12 follower defers to the lead unit
                        if (follower_mode) begin
                            lead_request <= 1'b1;
                            state        <= `AOCS_ST_GRANT;
                        end else begin
                            regen_active <= 1'b1;
                            target       <= next_pos(cycle_pos);
                            state        <= `AOCS_ST_MOVE;
                        end
                    // R13 R14 manual motor from service
                    end else if (manual_continuous || manual_step) begin
                        cont   <= manual_continuous;
                        target <= next_pos(cycle_pos);
                        state  <= `AOCS_ST_MOVE;
                    end
                end
                `AOCS_ST_GRANT: begin
                    // R12 wait for grant, may be cancelled
                    if (cancel_pending_trigger) begin
                        lead_request <= 1'b0;
                        state        <= `AOCS_ST_IDLE;
                    end else if (grant_sync) begin
                        lead_request <= 1'b0;
                        regen_active <= 1'b1;
                        target       <= next_pos(cycle_pos);
                        state        <= `AOCS_ST_MOVE;
                    end
                end
                `AOCS_ST_MOVE: begin
                    if (arrived) begin
                        cycle_pos <= target;
                        if (target == `AOCS_POS_SERVICE) begin
                            regen_active <= 1'b0;
                            cont         <= 1'b0;
                            minutes_left <= 8'h00;
                            state        <= `AOCS_ST_IDLE;
                        // R14 continuous run passes straight through
                        end else if (cont) begin
                            target <= next_pos(target);
                        end else if (regen_active) begin
                            // R13 minutes left in this position
                            minutes_left <= step_minutes(target, regen_step_minutes);
                            state        <= `AOCS_ST_DWELL;
                        end else begin
                            state <= `AOCS_ST_PARK;
                        end
                    end
                end
                `AOCS_ST_DWELL: begin
                    // R16 end regeneration at once
                    if (end_regen_now) begin
                        target <= `AOCS_POS_SERVICE;
                        state  <= `AOCS_ST_MOVE;
                    // R16 R13 advance on request or timeout
                    end else if (next_cycle || manual_step || manual_continuous ||
                                 minutes_left == 8'h00 ||
                                 (minute_tick && minutes_left == 8'h01)) begin
                        cont   <= manual_continuous;
                        target <= next_pos(cycle_pos);
                        state  <= `AOCS_ST_MOVE;
                    end else if (minute_tick) begin
                        minutes_left <= minutes_left - 8'h01;
                    end
                end
                `AOCS_ST_PARK: begin
                    // R14 stopped after a single step
                    if (manual_continuous || manual_step) begin
                        cont   <= manual_continuous;
                        target <= next_pos(cycle_pos);
                        state  <= `AOCS_ST_MOVE;
                    end
                end
                default: state <= `AOCS_ST_IDLE;
            endcase
        end
    end

    // motor stops the cycle the target switch is seen
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            motor_run <= 1'b0;
        end else begin
            motor_run <= (state == `AOCS_ST_MOVE) && !arrived;
        end
    end

    // R7 four independent channels
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_ch
            // R2 settled at the trigger position only
            aocs_aux_channel u_ch (
                .clk         (clk),
                .nrst        (nrst),
                .minute_tick (minute_tick),
                .in_trigger  ((cycle_pos == aux_trigger_pos[2*i+1:2*i]) &&
                              (state != `AOCS_ST_MOVE)),
                .mode        (aux_mode[2*i+1:2*i]),
                .delay_min   (activation_delay_minutes[8*i+7:8*i]),
                .on_min      (active_duration_minutes[8*i+7:8*i]),
                .off_min     (inactive_duration_minutes[8*i+7:8*i]),
                .out         (ch_out[i])
            );
        end
    endgenerate

    // R19 outputs load 0 in reset, channel defaults from the second edge after
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aux_out <= 4'h0;
        end else begin
            aux_out[2:1] <= ch_out[2:1];
            // R8 output one drives the valve motor
            aux_out[0] <= motor_on_aux1 ? motor_run : ch_out[0];
            // R8 R9 standby solenoid off only in service
            aux_out[3] <= motor_on_aux1 ?
                          (cycle_pos != `AOCS_POS_SERVICE || state == `AOCS_ST_MOVE) :
                          ch_out[3];
        end
    end

endmodule // aocs_sequencer

//--- testbench/aocs_seq_properties.sv
// port properties of the regeneration sequencer
`timescale 1ns/1ps
module aocs_seq_properties (
    input wire        clk,
    input wire        nrst,
    input wire        immediate_regeneration,
    input wire        follower_mode,
    input wire        motor_on_aux1,
    input wire [23:0] regen_step_minutes,
    input wire [3:0]  valve_switch,
    input wire [3:0]  aux_out,
    input wire        motor_run,
    input wire [1:0]  cycle_pos,
    input wire [7:0]  minutes_left,
    input wire        regen_active,
    input wire        lead_request,
    input wire        valve_at_service,
    input wire        valve_at_backwash
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // switch copies lag three edges, so skip the edges after reset
    logic [2:0] up;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) up <= 3'h0;
        else if (up != 3'h7) up <= up + 3'h1;
    end
    chk_imm_start: assert property (
        immediate_regeneration && !follower_mode && !regen_active && !motor_run
        && !lead_request |=> regen_active) else $error("immediate start missed");
    chk_motor_follows: assert property (
        $rose(regen_active) |-> ##[1:2] motor_run) else $error("motor did not start");
    chk_pos_report: assert property (
        up == 3'h7 |-> valve_at_service == $past(valve_switch[0], 3)
        && valve_at_backwash == $past(valve_switch[1], 3)) else $error("bad position report");
    chk_arrive_stop: assert property (
        regen_active && regen_step_minutes[7:0] != 8'h00 && $rose(valve_at_backwash)
        |-> !motor_run && cycle_pos == 2'h1) else $error("motor ran past backwash");
    chk_idle_minutes: assert property (
        !regen_active |-> minutes_left == 8'h00) else $error("minutes left outside regen");
    chk_follow_wait: assert property (
        follower_mode && lead_request |-> !regen_active) else $error("follower did not wait");
    chk_standby_on: assert property (
        motor_on_aux1 && $past(motor_on_aux1) && cycle_pos != 2'h0 |-> ##[0:2] aux_out[3])
        else $error("standby output off outside service");
    chk_standby_off: assert property (
        (motor_on_aux1 && cycle_pos == 2'h0 && !motor_run && !regen_active) [*3]
        |-> !aux_out[3]) else $error("standby output on in service");
    chk_aux1_motor: assert property (
        motor_on_aux1 && $past(motor_on_aux1) |-> aux_out[0] == $past(motor_run))
        else $error("output one not driving motor");
    cov_regen: cover property ($rose(regen_active));
    cov_lead: cover property ($rose(lead_request));
    cov_toggle: cover property ($rose(aux_out[2]));
endmodule // aocs_seq_properties

bind aocs_sequencer aocs_seq_properties aocs_seq_properties_inst (
    .clk(clk), .nrst(nrst), .immediate_regeneration(immediate_regeneration),
    .follower_mode(follower_mode), .motor_on_aux1(motor_on_aux1),
    .regen_step_minutes(regen_step_minutes), .valve_switch(valve_switch), .aux_out(aux_out),
    .motor_run(motor_run), .cycle_pos(cycle_pos), .minutes_left(minutes_left),
    .regen_active(regen_active), .lead_request(lead_request),
    .valve_at_service(valve_at_service), .valve_at_backwash(valve_at_backwash));

//--- testbench/aocs_valve_model.sv
// valve drive and lead unit stand-in
`timescale 1ns/1ps
module aocs_valve_model (
    input  wire       clk,
    input  wire       nrst,
    input  wire       motor_run,
    input  wire       lead_request,
    output reg  [3:0] valve_switch,
    output reg        lead_grant
);
    int pos;
    int t;
    int g;
    // one switch per position
    // no switch until the new position is reached, never the old one again
    always @* valve_switch = (t > 0 && t <= 10) ? 4'h0 : 4'h1 << pos;
    // travel takes ten cycles, then a dwell before a running motor moves it on
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pos <= 0;
            t <= 0;
        end else if (t == 0) begin
            t <= motor_run ? 1 : 0;
        end else begin
            t <= (t == 16) ? 0 : t + 1;
            if (t == 10) pos <= (pos + 1) % 4;
        end
    end
    always @(posedge clk or negedge nrst) begin
        if (!nrst) g <= 0;
        else g <= lead_request ? g + 1 : 0;
    end
    always @(posedge clk or negedge nrst) begin
        if (!nrst) lead_grant <= 1'b0;
        else lead_grant <= lead_request && g >= 5;
    end
endmodule // aocs_valve_model

//--- testbench/tb_top.sv
// self-checking bench for the regeneration sequencer
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [8:0]  req = 9'h000;
    logic        follower_mode = 1'b0;
    logic        motor_on_aux1 = 1'b0;
    logic [7:0]  mode = 8'h25;
    logic [7:0]  trig = 8'hE7;
    logic [31:0] dly = 32'h0000_0001;
    logic [31:0] on_min = 32'h0101_0101;
    // toggle channel needs an off time to switch more than once
    logic [31:0] off_min = 32'h0001_0000;
    logic [23:0] steps = 24'h040404;
    logic [10:0] tv = 11'h077;
    logic [10:0] rtv = 11'h078;
    wire  [3:0]  aux_out;
    wire  [3:0]  vsw;
    wire  [7:0]  minutes_left;
    wire  [1:0]  cycle_pos;
    wire         motor_run, regen_active, regen_pending, lead_request, lead_grant;
    wire         at_s, at_b, at_d, at_f;
    logic [3:0]  prev = 4'h0;
    int          rises[4];
    int          falls[4];
    int          fails = 0;
    int          check_count = 0;

    always #10 clk = ~clk;

    aocs_sequencer #(.MINUTE_CYCLES(64'h0000_0000_0000_0014)) aocs_sequencer_inst (
        .clk(clk), .nrst(nrst), .aux_mode(mode), .aux_trigger_pos(trig),
        .activation_delay_minutes(dly), .active_duration_minutes(on_min),
        .inactive_duration_minutes(off_min), .motor_on_aux1(motor_on_aux1),
        .regen_step_minutes(steps), .set_time(req[6]), .time_value(tv),
        .set_regen_time(req[5]), .regen_time_value(rtv), .deferred_regeneration(req[1]),
        .immediate_regeneration(req[0]), .next_cycle(req[3]), .end_regen_now(req[4]),
        .cancel_pending_trigger(req[2]), .manual_continuous(req[8]), .manual_step(req[7]),
        .follower_mode(follower_mode), .lead_grant(lead_grant), .valve_switch(vsw),
        .aux_out(aux_out), .motor_run(motor_run), .cycle_pos(cycle_pos),
        .minutes_left(minutes_left), .regen_active(regen_active),
        .regen_pending(regen_pending), .lead_request(lead_request), .valve_at_service(at_s),
        .valve_at_backwash(at_b), .valve_at_draw_rinse(at_d),
        .valve_at_fast_rinse_refill(at_f));

    aocs_valve_model aocs_valve_model_inst (
        .clk(clk), .nrst(nrst), .motor_run(motor_run), .lead_request(lead_request),
        .valve_switch(vsw), .lead_grant(lead_grant));

    always @(posedge clk) begin
        prev <= aux_out;
        for (int i = 0; i < 4; i++) begin
            if (aux_out[i] === 1'b1 && prev[i] === 1'b0) rises[i]++;
            if (aux_out[i] === 1'b0 && prev[i] === 1'b1) falls[i]++;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pulse(input int i);
        @(posedge clk) #1 req[i] = 1'b1;
        @(posedge clk) #1 req[i] = 1'b0;
    endtask

    task automatic wait_pos(input logic [1:0] p);
        for (int n = 0; n < 900 && cycle_pos !== p; n++) @(posedge clk) #1;
    endtask

    // reference walk: positions in order, dwell taken from the step table
    task automatic run_regen(input string name);
        int q[$];
        q = '{1, 2, 3, 0};
        foreach (rises[i]) rises[i] = 0;
        foreach (falls[i]) falls[i] = 0;
        foreach (q[k]) begin
            wait_pos(q[k][1:0]);
            chk(cycle_pos, q[k]);
            chk(minutes_left, q[k] ? steps[8 * q[k] - 8 +: 8] : 8'h00);
        end
        repeat (5) @(posedge clk) #1;
        chk(regen_active, 1'b0);
        chk({at_f, at_d, at_b, at_s}, 4'h1);
        chk(aux_out, 4'h8);
        chk(rises[0], 1);
        chk(rises[1], 1);
        chk(rises[2] >= 2, 1);
        chk(falls[3], 1);
        chk(rises[3], 1);
        $display("test %s done", name);
    endtask

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        void'($urandom(53));
        steps[7:0] = 8'h02 + 8'($urandom % 2);
        steps[23:16] = 8'h02 + 8'($urandom % 2);
        off_min[15:8] = 8'h01 + 8'($urandom % 4);
        repeat (12) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge clk) #1;
        chk(aux_out, 4'h8);
        chk(minutes_left, 8'h00);
        $display("test reset done");
        pulse(0);
        chk(regen_active, 1'b1);
        run_regen("immediate");
        pulse(1);
        pulse(2);
        chk(regen_pending, 1'b0);
        pulse(1);
        chk(regen_pending, 1'b1);
        pulse(5);
        pulse(6);
        run_regen("deferred");
        follower_mode = 1'b1;
        motor_on_aux1 = 1'b1;
        pulse(0);
        @(posedge clk) #1;
        chk(lead_request, 1'b1);
        chk(regen_active, 1'b0);
        wait_pos(2'h1);
        repeat (4) @(posedge clk) #1;
        chk(aux_out[3], 1'b1);
        chk(aux_out[0], 1'b0);
        pulse(3);
        wait_pos(2'h2);
        chk(cycle_pos, 2'h2);
        pulse(4);
        wait_pos(2'h0);
        repeat (6) @(posedge clk) #1;
        chk(regen_active, 1'b0);
        chk(aux_out[3], 1'b0);
        $display("test follower done");
        // single step parks, continuous runs on
        pulse(7);
        wait_pos(2'h1);
        repeat (4) @(posedge clk) #1;
        chk(motor_run, 1'b0);
        chk(regen_active, 1'b0);
        pulse(8);
        wait_pos(2'h2);
        repeat (4) @(posedge clk) #1;
        chk(motor_run, 1'b1);
        wait_pos(2'h0);
        repeat (6) @(posedge clk) #1;
        chk(motor_run, 1'b0);
        chk(cycle_pos, 2'h0);
        $display("test manual done");
        stop_test;
    end

    // three regenerations need well under 30000 cycles
    initial begin
        #(20 * 30000);
        fails++;
        stop_test;
    end
endmodule // tb_top
